// *** logic/sensor_err_pkg.sv ***
// Shared constants, carrier structs and state layout of the error and
// response logic. Assumes a single 20 MHz core clock domain.
package sensor_err_pkg;

    // Clock and link framing
    localparam int          CORE_CLK_HZ     = 20_000_000;
    localparam logic [4:0]  FRAME_EDGES     = 5'h10;        // 16 link clock rises per frame

    // Sample coding
    localparam int          SAMPLE_W        = 12;
    localparam int          CODE_W          = 4;
    localparam int          RESP_W          = CODE_W + SAMPLE_W;
    localparam logic [11:0] UNSIGNED_OFFSET = 12'h800;      // 2048 = zero acceleration
    localparam logic [11:0] LIN_POS_MAX     = 12'h780;      // +1920
    localparam logic [11:0] LIN_NEG_MIN     = 12'h880;      // -1920
    localparam logic [11:0] FAULT_UNSIGNED  = 12'h000;
    localparam logic [11:0] FAULT_SIGNED    = 12'h800;      // -2048, outside linear span

    // Response codes placed in the top bits of each answer word
    localparam logic [3:0]  RESP_DATA       = 4'h0;
    localparam logic [3:0]  RESP_SPI_ERR    = 4'h1;
    localparam logic [3:0]  RESP_MISO_ERR   = 4'h2;
    localparam logic [3:0]  RESP_INV_REQ    = 4'h3;
    localparam logic [3:0]  RESP_INV_ACCEL  = 4'h4;
    localparam logic [3:0]  RESP_INT_ERR    = 4'h5;
    localparam logic [3:0]  RESP_ST_ERR     = 4'h6;

    // Request kinds delivered by the frame decoder
    localparam logic [1:0]  REQ_ACCEL_X     = 2'h0;
    localparam logic [1:0]  REQ_ACCEL_Y     = 2'h1;
    localparam logic [1:0]  REQ_STATUS_RD   = 2'h2;
    localparam logic [1:0]  REQ_OTHER       = 2'h3;

    typedef struct packed {
        logic [1:0] kind;
        logic       spi_err;
        logic       miso_err;
        logic       invalid;
    } req_t;

    typedef struct packed {
        logic otp_crc;
        logic wreg_crc;
        logic clkmon_crc;
        logic selftest;
        logic logic_state;
        logic offset_x;
        logic offset_y;
    } fault_t;

    typedef struct packed {
        logic internal_error_flag;
        logic reset_seen_flag;
        logic offset_x_flag;
        logic offset_y_flag;
        logic otp_lock;
        logic wreg_lock;
        logic crc_cause;
        logic selftest_cause;
    } status_t;

    typedef struct packed {
        logic [CODE_W-1:0]   code;
        logic [SAMPLE_W-1:0] data;
    } resp_t;

    typedef struct packed {
        status_t    device_status_reg;
        logic       first_pending;
        logic       link_prev;
        logic       sel_prev;
        logic [4:0] edge_cnt;
        logic       pend_valid;
        resp_t      pend_word;
        logic       req_stall;
        logic       arm_update;
        logic       arm_axis;
        logic       pcm_enable;
        logic       sample_clipped;
    } core_state_t;

endpackage : sensor_err_pkg

// *** logic/pin_sync.sv ***
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes the pins are asynchronous to core_clk; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int               WIDTH     = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0      // Idle level of each pin
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // Refuse a zero-width bundle
    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync: WIDTH must be at least 1");
    end

    // First stage feeds the second stage and nothing else; both reset to
    // the idle level so the stages filling after reset fake no edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg     <= RESET_VAL;
            pin_sync_out <= RESET_VAL;
        end
        else
        begin
            meta_reg     <= pin_in;
            pin_sync_out <= meta_reg;
        end
    end

endmodule : pin_sync

`default_nettype wire

// *** logic/resp_buffer.sv ***
// Two-entry answer buffer with valid/ready on both sides.
// Assumes one clock; slot 0 is the head so the output comes from a register.
`timescale 1ns/1ps
`default_nettype none

module resp_buffer #(
    parameter int WIDTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);

    logic             tail_valid_reg;
    logic [WIDTH-1:0] tail_data_reg;
    logic             push;
    logic             pop;

    if (WIDTH < 1)
    begin : g_width_check
        $error("resp_buffer: WIDTH must be at least 1");
    end

    // Full only when both slots hold a word
    assign in_ready = !tail_valid_reg;
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;

    // Head and tail slots; the tail moves forward on a pop
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            out_valid      <= 1'b0;
            out_data       <= '0;
            tail_valid_reg <= 1'b0;
            tail_data_reg  <= '0;
        end
        else
        begin
            if (pop || !out_valid)
            begin
                if (tail_valid_reg)
                begin
                    out_valid      <= 1'b1;
                    out_data       <= tail_data_reg;
                    tail_valid_reg <= push;
                    tail_data_reg  <= in_data;
                end
                else
                begin
                    out_valid <= push;
                    out_data  <= in_data;
                end
            end
            else if (push)
            begin
                tail_valid_reg <= 1'b1;
                tail_data_reg  <= in_data;
            end
        end
    end

endmodule : resp_buffer

`default_nettype wire

// *** logic/sensor_error_response_logic.sv ***
// Fault latching, answer selection and sample coding of the sensor core.
// Assumes a frame decoder on core_clk presents req at the end of each frame
// and fault sources on core_clk; link clock and frame select are raw pins.
`timescale 1ns/1ps
`default_nettype none

module sensor_error_response_logic
    import sensor_err_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                link_clk_pin,
    input  wire logic                frame_sel_n_pin,
    input  wire req_t                req,
    input  wire fault_t              fault,
    input  wire logic                init_done_lock,
    input  wire logic                sample_signed,
    input  wire logic [SAMPLE_W-1:0] sample_x,
    input  wire logic [SAMPLE_W-1:0] sample_y,
    input  wire logic                sample_fault_x,
    input  wire logic                sample_fault_y,
    input  wire logic                resp_ready,
    output var  logic                resp_valid,
    output var  resp_t               resp,
    output var  logic                req_stall,
    output var  logic                arm_update,
    output var  logic                arm_axis,
    output var  logic                pcm_enable,
    output var  logic                sample_clipped,
    output var  status_t             device_status_reg
);

    core_state_t state_reg;
    core_state_t state_next;
    logic [1:0]  pins_synced;
    logic        link_lvl;
    logic        sel_n_lvl;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic [RESP_W-1:0] buf_out_data;

    // Pin levels cross into core_clk before anything looks at them; the
    // stages start at the idle levels, else a fake frame end follows reset
    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (2'b01)
    ) u_pin_sync (
        .core_clk     (core_clk),
        .rst          (rst),
        .pin_in       ({link_clk_pin, frame_sel_n_pin}),
        .pin_sync_out (pins_synced)
    );

    assign link_lvl  = pins_synced[1];
    assign sel_n_lvl = pins_synced[0];

    // Clamp to the linear span, then add the unsigned offset if asked
    function automatic logic [SAMPLE_W-1:0] code_sample(
        input logic [SAMPLE_W-1:0] raw,
        input logic                is_fault,
        input logic                is_signed
    );
        logic [SAMPLE_W-1:0] clamped;
        clamped = raw;
        if (!raw[SAMPLE_W-1] && (raw > LIN_POS_MAX))
        begin
            clamped = LIN_POS_MAX;
        end
        else if (raw[SAMPLE_W-1] && (raw < LIN_NEG_MIN))
        begin
            clamped = LIN_NEG_MIN;
        end
        if (is_fault)
        begin
            code_sample = is_signed ? FAULT_SIGNED : FAULT_UNSIGNED;
        end
        else if (is_signed)
        begin
            code_sample = clamped;
        end
        else
        begin
            code_sample = clamped + UNSIGNED_OFFSET;
        end
    endfunction : code_sample

    // Whether a raw sample falls outside the linear span
    function automatic logic out_of_span(input logic [SAMPLE_W-1:0] raw);
        out_of_span = (!raw[SAMPLE_W-1] && (raw > LIN_POS_MAX)) ||
                      (raw[SAMPLE_W-1] && (raw < LIN_NEG_MIN));
    endfunction : out_of_span

    // Next-state logic: framing, answer choice, then fault latching
    always_comb
    begin
        logic                link_rise;
        logic                frame_start;
        logic                frame_end;
        logic                eval;
        logic                spi_bad;
        logic                is_accel;
        logic                axis_y;
        logic                axis_offset;
        logic                status_rd_ok;
        logic                crc_now;
        logic [SAMPLE_W-1:0] raw;
        resp_t               word;
        status_t             st;

        link_rise    = 1'b0;
        frame_start  = 1'b0;
        frame_end    = 1'b0;
        eval         = 1'b0;
        spi_bad      = 1'b0;
        is_accel     = 1'b0;
        axis_y       = 1'b0;
        axis_offset  = 1'b0;
        status_rd_ok = 1'b0;
        crc_now      = 1'b0;
        raw          = '0;
        word         = '0;
        st           = state_reg.device_status_reg;
        state_next   = state_reg;

        state_next.arm_update = 1'b0;
        state_next.link_prev  = link_lvl;
        state_next.sel_prev   = sel_n_lvl;

        // Edges are found on synchronised levels only
        link_rise   = link_lvl && !state_reg.link_prev;
        frame_start = !sel_n_lvl && state_reg.sel_prev;
        frame_end   = sel_n_lvl && !state_reg.sel_prev;

        if (frame_start)
        begin
            state_next.edge_cnt = '0;
        end
        else if (!sel_n_lvl && link_rise && (state_reg.edge_cnt != 5'h1f))
        begin
            state_next.edge_cnt = state_reg.edge_cnt + 5'h01;
        end

        // A frame that ends while the last answer waits for the buffer is
        // held off by req_stall; the decoder must not end one then
        eval     = frame_end && !state_reg.pend_valid;
        spi_bad  = req.spi_err || (state_reg.edge_cnt != FRAME_EDGES);
        is_accel = (req.kind == REQ_ACCEL_X) || (req.kind == REQ_ACCEL_Y);
        axis_y   = (req.kind == REQ_ACCEL_Y);
        axis_offset = axis_y ? st.offset_y_flag : st.offset_x_flag;
        raw      = axis_y ? sample_y : sample_x;
        status_rd_ok = (req.kind == REQ_STATUS_RD) && !spi_bad &&
                       !req.miso_err && !req.invalid;

        if (eval)
        begin
            // Priority chain, highest first
            if (state_reg.first_pending)
            begin
                word.code = RESP_SPI_ERR;
                state_next.first_pending = 1'b0;
            end
            else if (spi_bad)
            begin
                word.code = RESP_SPI_ERR;
            end
            else if (req.miso_err)
            begin
                word.code = RESP_MISO_ERR;
            end
            else if (req.invalid)
            begin
                word.code = RESP_INV_REQ;
            end
            else if (is_accel && st.reset_seen_flag)
            begin
                word.code = RESP_INV_ACCEL;
            end
            else if (is_accel && (st.crc_cause || st.otp_lock || st.wreg_lock))
            begin
                word.code = RESP_INT_ERR;
            end
            else if (is_accel && st.selftest_cause)
            begin
                word.code = RESP_ST_ERR;
            end
            else if (is_accel && axis_offset)
            begin
                word.code = RESP_INT_ERR;
            end
            else if (is_accel)
            begin
                // Only a clean answer moves the arming function
                word.code = RESP_DATA;
                word.data = code_sample(raw,
                                        axis_y ? sample_fault_y : sample_fault_x,
                                        sample_signed);
                state_next.arm_update     = 1'b1;
                state_next.arm_axis       = axis_y;
                state_next.sample_clipped = out_of_span(raw);
            end
            else if (req.kind == REQ_STATUS_RD)
            begin
                word.code = RESP_DATA;
                word.data = {{(SAMPLE_W - 8){1'b0}}, st};
            end
            else
            begin
                word.code = RESP_DATA;
            end
            state_next.pend_valid = 1'b1;
            state_next.pend_word  = word;

            // A completed status read clears what may be cleared
            if (status_rd_ok && !state_reg.first_pending)
            begin
                st.reset_seen_flag = 1'b0;
                st.crc_cause       = 1'b0;
                st.selftest_cause  = 1'b0;
                st.offset_x_flag   = 1'b0;
                st.offset_y_flag   = 1'b0;
            end
        end
        else if (state_reg.pend_valid && buf_in_ready)
        begin
            state_next.pend_valid = 1'b0;
        end

        // Sets come after clears so a fault in the read cycle is kept
        crc_now = fault.otp_crc || fault.wreg_crc || fault.clkmon_crc ||
                  fault.logic_state;
        if (fault.otp_crc)
        begin
            st.otp_lock = 1'b1;
        end
        if (fault.wreg_crc && init_done_lock)
        begin
            st.wreg_lock = 1'b1;
        end
        if (crc_now)
        begin
            st.crc_cause = 1'b1;
        end
        if (fault.selftest)
        begin
            st.selftest_cause = 1'b1;
        end
        if (fault.offset_x)
        begin
            st.offset_x_flag = 1'b1;
        end
        if (fault.offset_y)
        begin
            st.offset_y_flag = 1'b1;
        end
        st.internal_error_flag = st.crc_cause || st.selftest_cause ||
                                 st.otp_lock || st.wreg_lock;
        state_next.device_status_reg = st;

        // Pulse-code output follows only the reset indication
        state_next.pcm_enable = !st.reset_seen_flag;
        state_next.req_stall  = state_next.pend_valid;
    end

    // State register; the reset-seen flag and first answer start armed
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg                                   <= '0;
            state_reg.first_pending                     <= 1'b1;
            state_reg.device_status_reg.reset_seen_flag <= 1'b1;
            state_reg.link_prev                         <= 1'b0;
            state_reg.sel_prev                          <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Answers wait here so a stalled receiver loses none
    resp_buffer #(
        .WIDTH (RESP_W)
    ) u_resp_buffer (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (state_reg.pend_valid),
        .in_ready  (buf_in_ready),
        .in_data   (state_reg.pend_word),
        .out_valid (buf_out_valid),
        .out_ready (resp_ready),
        .out_data  (buf_out_data)
    );

    // Outputs are register bits of the state or of the buffer head
    assign resp_valid        = buf_out_valid;
    assign resp              = resp_t'(buf_out_data);
    assign req_stall         = state_reg.req_stall;
    assign arm_update        = state_reg.arm_update;
    assign arm_axis          = state_reg.arm_axis;
    assign pcm_enable        = state_reg.pcm_enable;
    assign sample_clipped    = state_reg.sample_clipped;
    assign device_status_reg = state_reg.device_status_reg;

endmodule : sensor_error_response_logic

`default_nettype wire

// *** test/sensor_err_sva.sv ***
// Checker of answer codes, arming and status latching at the block ports.
// Assumes one core_clk domain and rst asynchronous, active high.
`timescale 1ns/1ps
`default_nettype none

module sensor_err_chk
    import sensor_err_pkg::*;
(
    input wire logic    core_clk,
    input wire logic    rst,
    input wire fault_t  fault,
    input wire logic    resp_ready,
    input wire logic    resp_valid,
    input wire resp_t   resp,
    input wire logic    arm_update,
    input wire logic    pcm_enable,
    input wire status_t device_status_reg
);
    logic taken_reg;
    logic taken_next;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Remembers whether any word has left since reset
    always_comb taken_next = taken_reg | (resp_valid & resp_ready);
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            taken_reg <= 1'b0;
        else
            taken_reg <= taken_next;

    first_word_a: assert property (resp_valid && !taken_reg |-> resp.code == RESP_SPI_ERR)
        else $error("first word after reset is not the spi error code");
    word_hold_a: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp))
        else $error("waiting answer word changed or vanished");
    fault_latch_a: assert property ((fault.otp_crc || fault.wreg_crc || fault.clkmon_crc
        || fault.selftest || fault.logic_state) |=> device_status_reg.internal_error_flag)
        else $error("internal fault not latched");
    arm_reset_a: assert property (arm_update |-> !$past(device_status_reg.reset_seen_flag))
        else $error("arming updated before reset flag was cleared");
    arm_fault_a: assert property (arm_update |-> !$past(device_status_reg.internal_error_flag))
        else $error("arming updated with internal error set");
    pcm_off_a: assert property (device_status_reg.reset_seen_flag |-> !pcm_enable)
        else $error("pulse code output on while reset flag set");
    offset_set_a: assert property (fault.offset_x |=> device_status_reg.offset_x_flag)
        else $error("offset fault on x not flagged");
    otp_keep_a: assert property (device_status_reg.otp_lock |=> device_status_reg.otp_lock)
        else $error("shadow array crc lock cleared");
    wreg_keep_a: assert property (device_status_reg.wreg_lock |=> device_status_reg.wreg_lock)
        else $error("writable crc lock cleared without reset");

    // Main scenarios reached
    cover property (arm_update);
    cover property (resp_valid && resp.code == RESP_ST_ERR);
    cover property (device_status_reg.wreg_lock && device_status_reg.otp_lock);
endmodule : sensor_err_chk

bind sensor_error_response_logic sensor_err_chk u_chk (
    .core_clk(core_clk), .rst(rst), .fault(fault), .resp_ready(resp_ready),
    .resp_valid(resp_valid), .resp(resp), .arm_update(arm_update),
    .pcm_enable(pcm_enable), .device_status_reg(device_status_reg)
);

`default_nettype wire

// *** test/host_master_model.sv ***
// Host master model: link clock, frame select and the decoded request.
// Assumes a 50 ns core clock; link clock 400 ns, parked low between frames.
`timescale 1ns/1ps
`default_nettype none

module host_master_model
    import sensor_err_pkg::*;
(
    output var logic link_clk_pin,
    output var logic frame_sel_n_pin,
    output var req_t req
);
    // Idle bus: select high, link clock still
    initial
    begin
        link_clk_pin = 1'b0;
        frame_sel_n_pin = 1'b1;
        req = '0;
    end

    // One frame of edges link rises, 16 when clean; errs gives spi, miso and
    // invalid flags; odd start offset keeps link edges off core edges
    task automatic frame(input logic [1:0] kind, input int edges = 16,
                         input logic [2:0] errs = 3'b000);
        req = req_t'({kind, errs});
        #113 frame_sel_n_pin = 1'b0;
        repeat (edges)
        begin
            #200 link_clk_pin = 1'b1;
            #200 link_clk_pin = 1'b0;
        end
        #200 frame_sel_n_pin = 1'b1;
        #387;
    endtask : frame
endmodule : host_master_model

`default_nettype wire

// *** test/sensor_error_response_logic_test.sv ***
// Self-checking bench of the error and response logic.
// Assumes the package, design, checker and host model compile first.
`timescale 1ns/1ps
`default_nettype none

module sensor_error_response_logic_test
    import sensor_err_pkg::*;
;
    typedef struct packed {
        logic        sgn;
        logic        flt;
        logic [11:0] smp;
        logic [11:0] exp;
    } row_t;

    logic    core_clk = 1'b0;
    logic    rst = 1'b1;
    logic    link_clk_pin;
    logic    frame_sel_n_pin;
    req_t    req;
    fault_t  fault = '0;
    logic    init_done_lock = 1'b0;
    logic    sample_signed = 1'b1;
    logic    sample_fault_x = 1'b0;
    logic    sample_fault_y = 1'b0;
    logic    resp_ready = 1'b0;
    logic    resp_valid;
    resp_t   resp;
    logic    req_stall;
    logic    arm_update;
    logic    arm_axis;
    logic    pcm_enable;
    logic    sample_clipped;
    status_t device_status_reg;
    logic [11:0] sample_x = 12'h000;
    logic [11:0] sample_y = 12'h005;
    int      error_cnt = 0;
    int      num_checks = 0;
    int      arm_cnt = 0;
    // Sign, fault, raw sample, expected code; clamping rows probe the span ends
    row_t    rows [10] = '{'{1, 0, 12'h000, 12'h000}, '{1, 0, 12'h780, 12'h780},
        '{1, 0, 12'h7ff, 12'h780}, '{1, 0, 12'h801, 12'h880}, '{1, 0, 12'hfff, 12'hfff},
        '{0, 0, 12'h000, 12'h800}, '{0, 0, 12'h780, 12'hf80}, '{0, 0, 12'h881, 12'h081},
        '{0, 0, 12'h800, 12'h080}, '{0, 1, 12'h123, 12'h000}};

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    // Arming pulses counted for per-frame comparison
    always @(posedge core_clk)
        if (arm_update === 1'b1)
            arm_cnt <= arm_cnt + 1;

    sensor_error_response_logic dut (
        .core_clk(core_clk), .rst(rst), .link_clk_pin(link_clk_pin),
        .frame_sel_n_pin(frame_sel_n_pin), .req(req), .fault(fault),
        .init_done_lock(init_done_lock), .sample_signed(sample_signed),
        .sample_x(sample_x), .sample_y(sample_y), .sample_fault_x(sample_fault_x),
        .sample_fault_y(sample_fault_y), .resp_ready(resp_ready), .resp_valid(resp_valid),
        .resp(resp), .req_stall(req_stall), .arm_update(arm_update), .arm_axis(arm_axis),
        .pcm_enable(pcm_enable), .sample_clipped(sample_clipped),
        .device_status_reg(device_status_reg)
    );

    host_master_model host (
        .link_clk_pin(link_clk_pin), .frame_sel_n_pin(frame_sel_n_pin), .req(req)
    );

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Waits for the head word under a bound, compares it, then takes it
    task automatic get(input string nm, input logic [15:0] exp, input logic [15:0] msk);
        int k;
        k = 0;
        @(posedge core_clk);
        #1;
        while (resp_valid !== 1'b1 && k < 40)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk(nm, exp & msk, resp & msk);
        resp_ready = 1'b1;
        @(posedge core_clk);
        #1 resp_ready = 1'b0;
    endtask : get

    task automatic xfer(input string nm, input logic [1:0] kind, input logic [15:0] exp,
                        input logic [15:0] msk, input int arm, input int edges = 16,
                        input logic [2:0] errs = 3'b000);
        int a;
        a = arm_cnt;
        host.frame(kind, edges, errs);
        get(nm, exp, msk);
        chk({nm, " arming"}, 16'(arm), 16'(arm_cnt - a));
        $display("test %s done", nm);
    endtask : xfer

    // One-cycle fault pulse, gone before the next request
    task automatic pulse(input logic [6:0] f);
        fault = fault_t'(f);
        @(posedge core_clk);
        #1 fault = '0;
    endtask : pulse

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (8) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        xfer("first", REQ_ACCEL_X, {RESP_SPI_ERR, 12'h000}, 16'hf000, 0);
        xfer("unread", REQ_ACCEL_X, {RESP_INV_ACCEL, 12'h000}, 16'hf000, 0);
        xfer("status", REQ_STATUS_RD, 16'h0040, 16'hffff, 0);
        for (int i = 0; i < 10; i++)
        begin
            sample_signed = rows[i].sgn;
            sample_fault_x = rows[i].flt;
            sample_x = rows[i].smp;
            xfer("sample", REQ_ACCEL_X, {RESP_DATA, rows[i].exp}, 16'hffff, 1);
            chk("clipped", 16'(i == 2 || i == 3 || i == 8), 16'(sample_clipped));
        end
        sample_signed = 1'b1;
        sample_fault_x = 1'b0;
        sample_x = 12'h000;
        pulse(7'h02);
        xfer("offset y", REQ_ACCEL_Y, 16'h0005, 16'hffff, 1);
        chk("axis", 16'h0001, 16'(arm_axis));
        xfer("offset x", REQ_ACCEL_X, {RESP_INT_ERR, 12'h000}, 16'hf000, 0);
        chk("pcm offset", 16'h0001, 16'(pcm_enable));
        pulse(7'h08);
        xfer("self test", REQ_ACCEL_X, {RESP_ST_ERR, 12'h000}, 16'hf000, 0);
        xfer("self stays", REQ_ACCEL_X, {RESP_ST_ERR, 12'h000}, 16'hf000, 0);
        xfer("status two", REQ_STATUS_RD, 16'h00a1, 16'hffff, 0);
        xfer("cleared", REQ_ACCEL_X, 16'h0000, 16'hffff, 1);
        // Receiver stalls: two words buffered, third waits and stalls requests
        sample_fault_y = 1'b1;
        repeat (3) host.frame(REQ_ACCEL_Y);
        chk("stall", 16'h0001, {15'h0000, req_stall});
        repeat (3) get("buffered", 16'h0800, 16'hffff);
        init_done_lock = 1'b1;
        pulse(7'h20);
        xfer("wreg crc", REQ_STATUS_RD, 16'h0086, 16'hffff, 0);
        xfer("wreg kept", REQ_ACCEL_X, {RESP_INT_ERR, 12'h000}, 16'hf000, 0);
        pulse(7'h48);
        xfer("otp crc", REQ_STATUS_RD, 16'h008f, 16'hffff, 0);
        pulse(7'h1c);
        xfer("crc first", REQ_ACCEL_X, {RESP_INT_ERR, 12'h000}, 16'hf000, 0);
        chk("pcm crc", 16'h0001, 16'(pcm_enable));
        // Link causes outrank the CRC locks still present
        xfer("short", REQ_ACCEL_X, {RESP_SPI_ERR, 12'h000}, 16'hf000, 0, 15, 3'b011);
        xfer("miso", REQ_ACCEL_X, {RESP_MISO_ERR, 12'h000}, 16'hf000, 0, 16, 3'b011);
        xfer("invalid", REQ_ACCEL_X, {RESP_INV_REQ, 12'h000}, 16'hf000, 0, 16, 3'b001);
        // Mid-run device reset is the only way out of the writable lock
        rst = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 rst = 1'b0;
        chk("status reset", 16'h0040, {8'h00, device_status_reg});
        chk("pcm reset", 16'h0000, 16'(pcm_enable));
        $display("test reset again done");
        repeat (2) @(posedge core_clk);
        #1;
        xfer("first again", REQ_ACCEL_X, {RESP_SPI_ERR, 12'h000}, 16'hf000, 0);
        close_out();
    end

    // About four times the expected run of some thirty frames
    initial
    begin
        #900000;
        error_cnt++;
        close_out();
    end
endmodule : sensor_error_response_logic_test

`default_nettype wire
